// ### src/gio_map.svh
`ifndef GIO_MAP_SVH
`define GIO_MAP_SVH

// Line count and index width
`define GIO_NUM_LINES 8
`define GIO_IDX_W 3

// Fixed radio front-end lines
`define GIO_RX_SW_LINE 3'h0
`define GIO_TX_SW_LINE 3'h1
`define GIO_RADIO_MASK 8'h03

// Default helper-function positions
`define GIO_PULLUP_LINE_RST 3'h2
`define GIO_WAKE_LINE_RST 3'h3
`define GIO_SENSE_LINE_RST 3'h4
`define GIO_DETACH_LINE_RST 3'h5

// Default helper-function enables (USB variant only)
`define GIO_PULLUP_EN_RST 1'h1
`define GIO_WAKE_EN_RST 1'h0
`define GIO_SENSE_EN_RST 1'h0
`define GIO_DETACH_EN_RST 1'h0

// Software state reset values
`define GIO_DIR_RST 8'h00
`define GIO_OUT_RST 8'h00

`endif

// ### src/gio_pkg.sv
package gio_pkg;

	typedef enum logic [1:0] {
		GIO_FN_PULLUP,
		GIO_FN_WAKE,
		GIO_FN_SENSE,
		GIO_FN_DETACH
	} gio_func_t;

	typedef enum logic {
		GIO_VAR_UART,
		GIO_VAR_USB
	} gio_variant_t;

	typedef enum logic {
		GIO_ST_HOLD,
		GIO_ST_RUN
	} gio_state_t;

endpackage

// ### src/gio_line_cell.sv
`timescale 1ns/1ps

module gio_line_cell (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Control
	input wire logic run_i,
	input wire logic sw_dir_i,
	input wire logic sw_out_i,
	input wire logic ovr_en_i,
	input wire logic ovr_oe_i,
	input wire logic ovr_out_i,
	// Pin
	input wire logic pad_i,
	output logic pad_o,
	output logic pad_oe_o,
	output logic pad_pd_o,
	output logic level_o
);

	logic oe_d;
	logic out_d;

	assign oe_d = run_i & (ovr_en_i ? ovr_oe_i : sw_dir_i);
	assign out_d = oe_d & (ovr_en_i ? ovr_out_i : sw_out_i);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pad_oe_o <= 1'b0; // R10
			pad_o <= 1'b0;
			pad_pd_o <= 1'b1; // R11
			level_o <= 1'b0;
		end else begin
			pad_oe_o <= oe_d; // R1
			pad_o <= out_d;
			pad_pd_o <= 1'b1; // R11
			level_o <= pad_i; // R14
		end
	end

endmodule // gio_line_cell

// ### src/gio_access_merge.sv
`timescale 1ns/1ps

module gio_access_merge (
	// Embedded application side
	input wire logic app_dir_we_i,
	input wire logic app_out_we_i,
	input wire logic [7:0] app_mask_i,
	input wire logic [7:0] app_wdata_i,
	// Host command side
	input wire logic host_dir_we_i,
	input wire logic host_out_we_i,
	input wire logic [7:0] host_mask_i,
	input wire logic [7:0] host_wdata_i,
	// Current state
	input wire logic [7:0] dir_i,
	input wire logic [7:0] out_i,
	// Merged next state
	output logic [7:0] dir_o,
	output logic [7:0] out_o
);

	// Merge by mask; application wins on overlapping bits, host bits there are dropped
	function automatic logic [7:0] gio_merge(input logic [7:0] cur, input logic a_we,
		input logic [7:0] a_m, input logic [7:0] a_d, input logic h_we,
		input logic [7:0] h_m, input logic [7:0] h_d);
		logic [7:0] am;
		logic [7:0] hm;
		am = a_m & {8{a_we}};
		hm = h_m & {8{h_we}} & ~am;
		gio_merge = (cur & ~am & ~hm) | (a_d & am) | (h_d & hm);
	endfunction

	assign dir_o = gio_merge(dir_i, app_dir_we_i, app_mask_i, app_wdata_i,
		host_dir_we_i, host_mask_i, host_wdata_i); // R2
	assign out_o = gio_merge(out_i, app_out_we_i, app_mask_i, app_wdata_i,
		host_out_we_i, host_mask_i, host_wdata_i); // R2

endmodule // gio_access_merge

// ### src/gio_port.sv
// Functional notes
// R1: Eight lines 7..0, each separately an input or a driven output.
// R2: Embedded application and host commands can both read and drive lines.
// R3: Line 0 drives the radio receive switch; board leaves it open.
// R4: Line 1 drives the radio transmit switch; board leaves it open.
// R5: Line 2 plain I/O on UART parts, USB pull-up drive on USB parts.
// R6: Line 3 plain I/O on UART parts; USB parts select I/O or wake.
// R7: Line 4 plain I/O on UART parts; USB parts may select power sense.
// R8: Line 5 plain I/O on UART parts; USB parts may select detach request.
// R9: USB helper functions can be remapped to any of the eight lines; the code masks off radio lines 0 and 1.
// R10: During reset all bidirectional pins are inputs, outputs tristated.
// R11: Every line carries a weak pull-down, also after reset.
// R12: External reset source should hold reset longer than 5 ms.
// R13: External reset source must reset the module at every power-up.
// R14: Direction and output bit per line; pin level always readable.
`timescale 1ns/1ps
`include "gio_map.svh"

module gio_port (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Variant strap
	input wire logic usb_variant_i,
	// Embedded application access
	input wire logic app_dir_we_i,
	input wire logic app_out_we_i,
	input wire logic [7:0] app_mask_i,
	input wire logic [7:0] app_wdata_i,
	input wire logic app_rd_i,
	output logic [7:0] app_rdata_o,
	output logic app_rvalid_o,
	// Host command access
	input wire logic host_dir_we_i,
	input wire logic host_out_we_i,
	input wire logic [7:0] host_mask_i,
	input wire logic [7:0] host_wdata_i,
	input wire logic host_rd_i,
	output logic [7:0] host_rdata_o,
	output logic host_rvalid_o,
	// Helper-function map
	input wire logic func_map_we_i,
	input wire logic [1:0] func_sel_i,
	input wire logic [2:0] func_line_i,
	input wire logic func_en_i,
	// Radio front-end and USB helper signals
	input wire logic rx_switch_ctrl_i,
	input wire logic tx_switch_ctrl_i,
	input wire logic bus_pullup_drive_i,
	input wire logic bus_wake_signal_i,
	output logic bus_power_sense_o,
	output logic bus_detach_request_o,
	// Software state readback
	output logic [7:0] dir_o,
	output logic [7:0] out_o,
	output logic [7:0] level_o,
	output logic usb_variant_o,
	// General I/O pins
	input wire logic [7:0] general_io_line_i,
	output logic [7:0] general_io_line_o,
	output logic [7:0] general_io_line_oe_o,
	output logic [7:0] general_io_line_pd_o
);

	// One-hot decode of a line index
	function automatic logic [7:0] gio_onehot(input logic [2:0] idx);
		gio_onehot = 8'h01 << idx;
	endfunction

	gio_pkg::gio_state_t state_q;
	gio_pkg::gio_state_t state_d;
	gio_pkg::gio_variant_t variant_q;
	logic [7:0] dir_q;
	logic [7:0] out_q;
	logic [7:0] dir_d;
	logic [7:0] out_d;
	logic [2:0] fn_line_q [4];
	logic fn_en_q [4];
	logic [7:0] level_w;
	logic run_w;
	logic usb_w;
	logic [7:0] hot_pu;
	logic [7:0] hot_wk;
	logic [7:0] hot_ps;
	logic [7:0] hot_dt;
	logic [7:0] radio_m;
	logic [7:0] radio_v;
	logic [7:0] ovr_en;
	logic [7:0] ovr_oe;
	logic [7:0] ovr_out;
	logic sense_d;
	logic detach_d;

	// Reset hold then run
	always_comb begin
		case (state_q)
			gio_pkg::GIO_ST_HOLD: state_d = gio_pkg::GIO_ST_RUN;
			gio_pkg::GIO_ST_RUN: state_d = gio_pkg::GIO_ST_RUN;
			default: state_d = gio_pkg::GIO_ST_HOLD;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= gio_pkg::GIO_ST_HOLD; // R10
		end else begin
			state_q <= state_d;
		end
	end

	// Variant strap follows the pin while reset is held
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			variant_q <= usb_variant_i ? gio_pkg::GIO_VAR_USB : gio_pkg::GIO_VAR_UART;
		end
	end

	assign run_w = (state_q == gio_pkg::GIO_ST_RUN);
	assign usb_w = (variant_q == gio_pkg::GIO_VAR_USB);

	// Software direction and output state
	gio_access_merge u_merge (
		.app_dir_we_i(app_dir_we_i),
		.app_out_we_i(app_out_we_i),
		.app_mask_i(app_mask_i),
		.app_wdata_i(app_wdata_i),
		.host_dir_we_i(host_dir_we_i),
		.host_out_we_i(host_out_we_i),
		.host_mask_i(host_mask_i),
		.host_wdata_i(host_wdata_i),
		.dir_i(dir_q),
		.out_i(out_q),
		.dir_o(dir_d),
		.out_o(out_d)
	);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dir_q <= `GIO_DIR_RST; // R10
			out_q <= `GIO_OUT_RST;
		end else begin
			dir_q <= dir_d; // R14
			out_q <= out_d; // R14
		end
	end

	// Helper-function map, indexed by function
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fn_line_q[gio_pkg::GIO_FN_PULLUP] <= `GIO_PULLUP_LINE_RST; // R5
			fn_line_q[gio_pkg::GIO_FN_WAKE] <= `GIO_WAKE_LINE_RST; // R6
			fn_line_q[gio_pkg::GIO_FN_SENSE] <= `GIO_SENSE_LINE_RST; // R7
			fn_line_q[gio_pkg::GIO_FN_DETACH] <= `GIO_DETACH_LINE_RST; // R8
			fn_en_q[gio_pkg::GIO_FN_PULLUP] <= `GIO_PULLUP_EN_RST;
			fn_en_q[gio_pkg::GIO_FN_WAKE] <= `GIO_WAKE_EN_RST;
			fn_en_q[gio_pkg::GIO_FN_SENSE] <= `GIO_SENSE_EN_RST;
			fn_en_q[gio_pkg::GIO_FN_DETACH] <= `GIO_DETACH_EN_RST;
		end else if (func_map_we_i) begin
			fn_line_q[func_sel_i] <= func_line_i; // R9
			fn_en_q[func_sel_i] <= func_en_i; // R6
		end
	end

	// Helper functions only exist on USB parts; radio lines are never taken
	assign radio_m = `GIO_RADIO_MASK;
	assign radio_v = gio_onehot(`GIO_RX_SW_LINE) & {8{rx_switch_ctrl_i}}
		| gio_onehot(`GIO_TX_SW_LINE) & {8{tx_switch_ctrl_i}}; // R3 R4
	assign hot_pu = gio_onehot(fn_line_q[gio_pkg::GIO_FN_PULLUP]) & ~radio_m
		& {8{usb_w & fn_en_q[gio_pkg::GIO_FN_PULLUP]}}; // R5
	assign hot_wk = gio_onehot(fn_line_q[gio_pkg::GIO_FN_WAKE]) & ~radio_m & ~hot_pu
		& {8{usb_w & fn_en_q[gio_pkg::GIO_FN_WAKE]}}; // R6
	assign hot_ps = gio_onehot(fn_line_q[gio_pkg::GIO_FN_SENSE]) & ~radio_m
		& {8{usb_w & fn_en_q[gio_pkg::GIO_FN_SENSE]}}; // R7
	assign hot_dt = gio_onehot(fn_line_q[gio_pkg::GIO_FN_DETACH]) & ~radio_m
		& {8{usb_w & fn_en_q[gio_pkg::GIO_FN_DETACH]}}; // R8

	// Output helpers beat input helpers when mapped to one line
	assign ovr_en = radio_m | hot_pu | hot_wk | hot_ps | hot_dt; // R9
	assign ovr_oe = radio_m | hot_pu | hot_wk; // R3 R4
	assign ovr_out = (radio_v & radio_m)
		| (hot_pu & {8{bus_pullup_drive_i}})
		| (hot_wk & {8{bus_wake_signal_i}}); // R5 R6

	// Input helpers read the sampled pin level
	assign sense_d = |(hot_ps & ~hot_pu & ~hot_wk & level_w); // R7
	assign detach_d = |(hot_dt & ~hot_pu & ~hot_wk & level_w); // R8

	genvar gi;
	generate
		for (gi = 0; gi < `GIO_NUM_LINES; gi++) begin : g_line
			gio_line_cell u_cell (
				.clk_i(clk_i),
				.srst_i(srst_i),
				.run_i(run_w),
				.sw_dir_i(dir_q[gi]),
				.sw_out_i(out_q[gi]),
				.ovr_en_i(ovr_en[gi]),
				.ovr_oe_i(ovr_oe[gi]),
				.ovr_out_i(ovr_out[gi]),
				.pad_i(general_io_line_i[gi]),
				.pad_o(general_io_line_o[gi]),
				.pad_oe_o(general_io_line_oe_o[gi]),
				.pad_pd_o(general_io_line_pd_o[gi]),
				.level_o(level_w[gi])
			); // R1 R11
		end
	endgenerate

	// Readback and helper outputs
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			app_rdata_o <= 8'h00;
			app_rvalid_o <= 1'b0;
			host_rdata_o <= 8'h00;
			host_rvalid_o <= 1'b0;
			bus_power_sense_o <= 1'b0;
			bus_detach_request_o <= 1'b0;
			dir_o <= `GIO_DIR_RST;
			out_o <= `GIO_OUT_RST;
			level_o <= 8'h00;
			usb_variant_o <= 1'b0;
		end else begin
			app_rdata_o <= app_rd_i ? level_w : app_rdata_o; // R2
			app_rvalid_o <= app_rd_i;
			host_rdata_o <= host_rd_i ? level_w : host_rdata_o; // R2
			host_rvalid_o <= host_rd_i;
			bus_power_sense_o <= sense_d; // R7
			bus_detach_request_o <= detach_d; // R8
			dir_o <= dir_q;
			out_o <= out_q;
			level_o <= level_w; // R14
			usb_variant_o <= usb_w;
		end
	end

endmodule // gio_port

// ### tb/gio_port_properties.sv
`timescale 1ns/1ps
module gio_port_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Access and radio inputs
	input wire logic app_dir_we_i,
	input wire logic app_out_we_i,
	input wire logic [7:0] app_mask_i,
	input wire logic [7:0] app_wdata_i,
	input wire logic app_rd_i,
	input wire logic app_rvalid_o,
	input wire logic host_rd_i,
	input wire logic host_rvalid_o,
	input wire logic rx_switch_ctrl_i,
	input wire logic tx_switch_ctrl_i,
	// State and pins
	input wire logic [7:0] dir_o,
	input wire logic [7:0] out_o,
	input wire logic usb_variant_o,
	input wire logic [7:0] general_io_line_o,
	input wire logic [7:0] general_io_line_oe_o,
	input wire logic [7:0] general_io_line_pd_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	// Write taken, result visible two edges on
	sequence s_wr(we);
		we ##2 1'b1;
	endsequence
	property p_rst;
		disable iff (1'b0) srst_i |=> general_io_line_oe_o == 8'h00 && general_io_line_o == 8'h00;
	endproperty
	property p_pd;
		general_io_line_pd_o == 8'hff;
	endproperty
	property p_arv;
		app_rd_i |=> app_rvalid_o;
	endproperty
	property p_hrv;
		host_rd_i |=> host_rvalid_o;
	endproperty
	property p_dir;
		s_wr(app_dir_we_i) |-> ((dir_o ^ $past(app_wdata_i, 2)) & $past(app_mask_i, 2)) == 8'h00;
	endproperty
	property p_out;
		s_wr(app_out_we_i) |-> ((out_o ^ $past(app_wdata_i, 2)) & $past(app_mask_i, 2)) == 8'h00;
	endproperty
	property p_uart;
		!usb_variant_o |-> general_io_line_oe_o[7:2] == dir_o[7:2]
			&& general_io_line_o[7:2] == (dir_o[7:2] & out_o[7:2]);
	endproperty
	property p_radio;
		!$past(srst_i) && !$past(srst_i, 2) |-> general_io_line_oe_o[1:0] == 2'h3
			&& general_io_line_o[1:0] == {$past(tx_switch_ctrl_i), $past(rx_switch_ctrl_i)};
	endproperty
	a_rst: assert property (p_rst) else $error("pins driven in reset");
	a_pd: assert property (p_pd) else $error("pull-down missing");
	a_arv: assert property (p_arv) else $error("app read not answered");
	a_hrv: assert property (p_hrv) else $error("host read not answered");
	a_dir: assert property (p_dir) else $error("direction write lost");
	a_out: assert property (p_out) else $error("output write lost");
	a_uart: assert property (p_uart) else $error("plain line drive wrong");
	a_radio: assert property (p_radio) else $error("radio switch drive wrong");
endmodule // gio_port_chk

bind gio_port gio_port_chk u_gio_port_chk (.*);

// ### tb/gio_board.sv
`timescale 1ns/1ps
module gio_board (
	// Device side
	input wire logic [7:0] drive_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] pd_i,
	// Board side
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_val_i,
	output logic [7:0] pin_o
);
	// Radio lines left open
	wire logic [7:0] ext_on = ext_en_i & 8'hfc;
	assign pin_o = (oe_i & drive_i) | (~oe_i & ext_on & ext_val_i)
		| (~oe_i & ~ext_on & ~pd_i & ~drive_i);
endmodule // gio_board

// ### tb/programmable_io_port_bench.sv
`timescale 1ns/1ps
module programmable_io_port_bench;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic usb_variant_i = 1'b0;
	logic app_dir_we_i = 1'b0, app_out_we_i = 1'b0, app_rd_i = 1'b0;
	logic host_dir_we_i = 1'b0, host_out_we_i = 1'b0, host_rd_i = 1'b0;
	logic [7:0] app_mask_i = 8'h00, app_wdata_i = 8'h00;
	logic [7:0] host_mask_i = 8'h00, host_wdata_i = 8'h00;
	logic func_map_we_i = 1'b0, func_en_i = 1'b0;
	logic [1:0] func_sel_i = 2'h0;
	logic [2:0] func_line_i = 3'h0;
	logic rx_switch_ctrl_i = 1'b1, tx_switch_ctrl_i = 1'b0;
	logic bus_pullup_drive_i = 1'b1, bus_wake_signal_i = 1'b1;
	logic [7:0] app_rdata_o, host_rdata_o, dir_o, out_o, level_o, general_io_line_i;
	logic [7:0] general_io_line_o, general_io_line_oe_o, general_io_line_pd_o;
	logic app_rvalid_o, host_rvalid_o, bus_power_sense_o, bus_detach_request_o, usb_variant_o;
	int n_errors = 0;
	int cmp_count = 0;

	always #20 clk_i = ~clk_i;

	gio_port u_gio_port (.*);
	gio_board u_gio_board (
		.drive_i(general_io_line_o),
		.oe_i(general_io_line_oe_o),
		.pd_i(general_io_line_pd_o),
		.ext_en_i(8'hbc),
		.ext_val_i(8'h94),
		.pin_o(general_io_line_i)
	);

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic rst(input logic u);
		@(posedge clk_i);
		srst_i <= 1'b1;
		usb_variant_i <= u;
		// Hold kept far below the board minimum so runs stay short
		tk(4);
		chk("oe", 8'h00, general_io_line_oe_o);
		chk("pd", 8'hff, general_io_line_pd_o);
		@(posedge clk_i);
		srst_i <= 1'b0;
		tk(3);
	endtask

	// Write enables ordered app dir, app out, host dir, host out
	task automatic wr(input logic [3:0] we, input logic [7:0] am, ad, hm, hd);
		@(posedge clk_i);
		{app_dir_we_i, app_out_we_i, host_dir_we_i, host_out_we_i} <= we;
		app_mask_i <= am;
		app_wdata_i <= ad;
		host_mask_i <= hm;
		host_wdata_i <= hd;
		@(posedge clk_i);
		{app_dir_we_i, app_out_we_i, host_dir_we_i, host_out_we_i} <= 4'h0;
		tk(2);
	endtask

	task automatic rd(input logic h, input logic [7:0] e);
		int i;
		@(posedge clk_i);
		if (h)
			host_rd_i <= 1'b1;
		else
			app_rd_i <= 1'b1;
		@(posedge clk_i);
		{app_rd_i, host_rd_i} <= 2'h0;
		i = 0;
		#1;
		while ((h ? host_rvalid_o : app_rvalid_o) !== 1'b1 && i < 4) begin
			@(posedge clk_i);
			#1;
			i++;
		end
		if (i == 4) begin
			n_errors++;
			$display("ERROR rvalid expected 1 seen 0");
			summarize();
		end else
			chk("rdata", e, h ? host_rdata_o : app_rdata_o);
	endtask

	task automatic fmap(input logic [1:0] s, input logic [2:0] l, input logic en);
		@(posedge clk_i);
		func_map_we_i <= 1'b1;
		func_sel_i <= s;
		func_line_i <= l;
		func_en_i <= en;
		@(posedge clk_i);
		func_map_we_i <= 1'b0;
		tk(4);
	endtask

	initial begin
		rst(1'b0);
		chk("usb", 8'h00, {7'h00, usb_variant_o});
		chk("dir", 8'h00, dir_o);
		chk("out", 8'h00, out_o);
		rd(1'b0, 8'h95);
		$display("reset test done");
		wr(4'h8, 8'hfc, 8'hf0, 8'h00, 8'h00);
		wr(4'h1, 8'h00, 8'h00, 8'hff, 8'ha0);
		wr(4'h5, 8'h30, 8'h00, 8'h60, 8'h60);
		chk("out", 8'hc0, out_o);
		@(posedge clk_i);
		{tx_switch_ctrl_i, rx_switch_ctrl_i} <= 2'h2;
		tk(2);
		chk("oe", 8'hf3, general_io_line_oe_o);
		chk("drive", 8'hc2, general_io_line_o);
		rd(1'b1, 8'hc6);
		chk("level", 8'hc6, level_o);
		wr(4'h2, 8'h00, 8'h00, 8'h0c, 8'h04);
		chk("dir", 8'hf4, dir_o);
		chk("oe", 8'hf7, general_io_line_oe_o);
		$display("uart test done");
		rst(1'b1);
		chk("usb", 8'h01, {7'h00, usb_variant_o});
		chk("oe", 8'h07, general_io_line_oe_o);
		chk("drive", 8'h06, general_io_line_o);
		chk("sense", 8'h00, {7'h00, bus_power_sense_o});
		fmap(2'h1, 3'h3, 1'b1);
		chk("oe", 8'h0f, general_io_line_oe_o);
		fmap(2'h2, 3'h4, 1'b1);
		chk("sense", 8'h01, {7'h00, bus_power_sense_o});
		fmap(2'h3, 3'h7, 1'b1);
		chk("detach", 8'h01, {7'h00, bus_detach_request_o});
		fmap(2'h3, 3'h5, 1'b1);
		chk("detach", 8'h00, {7'h00, bus_detach_request_o});
		fmap(2'h0, 3'h6, 1'b1);
		chk("oe", 8'h4b, general_io_line_oe_o);
		chk("drive", 8'h4a, general_io_line_o);
		@(posedge clk_i);
		bus_pullup_drive_i <= 1'b0;
		bus_wake_signal_i <= 1'b0;
		tk(2);
		chk("drive", 8'h02, general_io_line_o);
		@(posedge clk_i);
		bus_wake_signal_i <= 1'b1;
		fmap(2'h1, 3'h0, 1'b1);
		chk("oe", 8'h43, general_io_line_oe_o);
		chk("drive", 8'h02, general_io_line_o);
		fmap(2'h0, 3'h6, 1'b0);
		chk("oe", 8'h03, general_io_line_oe_o);
		$display("usb test done");
		summarize();
	end
endmodule // programmable_io_port_bench
